// ==== rtl/bsp_params.svh ====
// Register offsets, field positions, reset values and codes of the serial port
`ifndef BSP_PARAMS_SVH
`define BSP_PARAMS_SVH

`define BSP_OFS_DATA      3'h0
`define BSP_OFS_IER       3'h1
`define BSP_OFS_EIR       3'h2
`define BSP_OFS_BANKSEL   3'h3
`define BSP_OFS_MCR       3'h4
`define BSP_OFS_LSR       3'h5
`define BSP_OFS_MSR       3'h6
`define BSP_OFS_SPR       3'h7
`define BSP_OFS_DIV_LOW   3'h0
`define BSP_OFS_DIV_HIGH  3'h1
`define BSP_OFS_EXTENDED_CONTROL_ONE     3'h2
`define BSP_OFS_EXTENDED_CONTROL_TWO     3'h4
`define BSP_OFS_TX_FIFO_LEVEL     3'h6
`define BSP_OFS_RX_FIFO_LEVEL     3'h7
`define BSP_OFS_MODULE_REVISION      3'h0
`define BSP_OFS_LINE_FORMAT_SHADOW    3'h1
`define BSP_OFS_FIFO_CONTROL_SHADOW    3'h2

`define BSP_BSEL_FLAG     7
`define BSP_BSEL_BANK1    7'h00
`define BSP_BSEL_BANK2    7'h60
`define BSP_BSEL_BANK3    7'h64

`define BSP_RST_LCR       8'h03
`define BSP_RST_FCR       8'h01
`define BSP_RST_DIV       16'h000c
`define BSP_RST_REG       8'h00

`define BSP_FCR_EN        0
`define BSP_FCR_RXSR      1
`define BSP_FCR_TXSR      2
`define BSP_LCR_STB       2
`define BSP_LCR_PEN       3
`define BSP_LCR_EPS       4
`define BSP_LCR_STKP      5
`define BSP_LCR_SBRK      6
`define BSP_MCR_DTR       0
`define BSP_MCR_RTS       1
`define BSP_MCR_RILP      2
`define BSP_MCR_DCDLP     3
`define BSP_MCR_LOOP      4
`define BSP_EXTENDED_CONTROL_ONE_EXT     0
`define BSP_EXTENDED_CONTROL_ONE_LOOP    4

`define BSP_EV_RX         0
`define BSP_EV_TXLOW      1
`define BSP_EV_LS         2
`define BSP_EV_MS         3
`define BSP_EV_TXEMP      5
`define BSP_EV_MASK_LEG   8'h0f
`define BSP_EV_MASK_EXT   8'h2f

`define BSP_OVERSAMPLE    16

`endif

// ==== rtl/bsp_pkg.sv ====
// Types shared by the serial port modules
package bsp_pkg;
	typedef enum logic [2:0] {
		BSP_MODE_BASIC = 3'b001,
		BSP_MODE_FIFO  = 3'b010,
		BSP_MODE_EXT   = 3'b100
	} bsp_mode_e;
	typedef enum logic [1:0] {
		BSP_TX_IDLE  = 2'b01,
		BSP_TX_SHIFT = 2'b10
	} bsp_tx_e;
	typedef enum logic [3:0] {
		BSP_RX_IDLE  = 4'b0001,
		BSP_RX_START = 4'b0010,
		BSP_RX_DATA  = 4'b0100,
		BSP_RX_STOP  = 4'b1000
	} bsp_rx_e;
endpackage : bsp_pkg

// ==== rtl/bsp_fifo.sv ====
// Byte FIFO with registered head data
`timescale 1ns/1ns
`default_nettype none
module bsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int LVL_W = $clog2(DEPTH + 1)
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_in,
	input  wire logic             flush_in,
	input  wire logic             push_in,
	input  wire logic [WIDTH-1:0] wdata_in,
	input  wire logic             pop_in,
	output logic      [WIDTH-1:0] rdata_out,
	output logic                  full_out,
	output logic                  empty_out,
	output logic      [LVL_W-1:0] level_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW-1:0]    nxt_rd_ptr;
	logic [LVL_W-1:0] count_ff;
	logic             do_push;
	logic             do_pop;

	assign do_push   = push_in && !full_out;
	assign do_pop    = pop_in && !empty_out;
	assign full_out  = (count_ff == LVL_W'(DEPTH));
	assign empty_out = (count_ff == '0);
	assign level_out = count_ff;
	assign nxt_rd_ptr = do_pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;

	always_ff @(posedge mclk_in) begin
		if (do_push) begin
			mem[wr_ptr_ff] <= wdata_in;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
			rdata_out <= '0;
		end else if (flush_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= count_ff + LVL_W'(do_push) - LVL_W'(do_pop);
			// Head bypass when the written word becomes the head
			if (do_push && (nxt_rd_ptr == wr_ptr_ff)) begin
				rdata_out <= wdata_in;
			end else begin
				rdata_out <= mem[nxt_rd_ptr];
			end
		end
	end
endmodule : bsp_fifo
`default_nettype wire

// ==== rtl/bsp_baud_gen.sv ====
// Oversampling tick generator driven by a 16-bit divisor
`timescale 1ns/1ns
`default_nettype none
module bsp_baud_gen (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic [15:0] divisor_in,
	output logic             tick_out
);
	logic [15:0] count_ff;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			count_ff <= 16'h0000;
			tick_out <= 1'b0;
		end else if (count_ff == 16'h0000) begin
			// Divisor 0 behaves as 1
			count_ff <= (divisor_in > 16'h0001) ? divisor_in - 16'h0001 : 16'h0000;
			tick_out <= 1'b1;
		end else begin
			count_ff <= count_ff - 16'h0001;
			tick_out <= 1'b0;
		end
	end
endmodule : bsp_baud_gen
`default_nettype wire

// ==== rtl/bsp_serial_port.sv ====
// Banked serial port: APB register file, transmitter, receiver, modem lines
`timescale 1ns/1ns
`default_nettype none
`include "bsp_params.svh"
// Summary of operation
// R1 - Basic legacy, FIFO legacy and extended operating modes are selectable.
// R2 - Transmitter and receiver run independently and at the same time.
// R3 - Host bytes become serial characters; received characters become bytes.
// R4 - Bit timing is generated for sending and recognised on reception.
// R5 - Reset and legacy divisor setup fall back to FIFO legacy mode; divisor setup in the code clears extended mode but leaves FIFO enable as is.
// R6 - Four banks of eight registers share offsets 0 to 7.
// R7 - Bank selector sits at offset 3 in every bank.
// R8 - Bank 0 is active after reset.
// R9 - Bank 0 offsets 0 and 2 differ between read and write.
// R10 - Offset 3 writes reach format control or bank selector by value.
// R11 - Offset 7 is scratch pad, or read-only aux status when extended; the code reads it as zero and ignores writes then.
// R12 - Bank 1 holds the legacy 16-bit divisor setting the bit rate.
// R13 - Bank 2 holds alternative divisor, extended controls, FIFO levels.
// R14 - Bank 3 offset 0 returns module code and revision code.
// R15 - Bank 3 returns copies of format control and FIFO setup.
// R16 - Line status and modem status report all communication phases.
// R17 - Selector bit 7 is the flag; bits 6 to 0 pick the bank.
// R18 - Reserved offsets ignore writes and read as zero.
module bsp_serial_port #(
	parameter int         FIFO_DEPTH    = 16,
	parameter logic [3:0] MODULE_CODE   = 4'h5, // Arbitrary value
	parameter logic [3:0] REVISION_CODE = 4'h1  // Arbitrary value
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [4:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        rxd_in,
	input  wire logic        cts_n_in,
	input  wire logic        dsr_n_in,
	input  wire logic        ri_n_in,
	input  wire logic        dcd_n_in,
	output logic             txd_out,
	output logic             rts_n_out,
	output logic             dtr_n_out,
	output logic             irq_out
);
	import bsp_pkg::*;
	localparam int LVL_W = $clog2(FIFO_DEPTH + 1);

	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16 ||
	    (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two from 2 to 16");
	end

	logic [7:0]  ier_ff, lcr_ff, bsel_ff, mcr_ff, spr_ff;
	logic [7:0]  extended_control_one_ff, extended_control_two_ff, fcr_ff, evt_ff, rd_val;
	logic [15:0] ldiv_ff, adiv_ff;
	logic [1:0]  bank_ff;
	logic        oe_ff, pe_ff, fe_ff, brk_ff;
	logic [3:0]  dlt_ff, mdm_prev_ff, mdm_now;
	logic [4:0]  pin_meta_ff, pin_sync_ff;
	logic        acc_fire, wr, rd, ext, loop, tick;
	logic [2:0]  ofs;
	logic [7:0]  wd;
	bsp_mode_e   mode;

	// Two-flop synchronisers: {dcd_n, ri_n, dsr_n, cts_n, rxd}
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_meta_ff <= 5'h1f;
			pin_sync_ff <= 5'h1f;
		end else begin
			pin_meta_ff <= {dcd_n_in, ri_n_in, dsr_n_in, cts_n_in, rxd_in};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// APB: one wait state, side effects once per transfer
	assign acc_fire = psel_in && penable_in && !pready_out;
	assign wr  = acc_fire && pwrite_in;
	assign rd  = acc_fire && !pwrite_in;
	assign ofs = paddr_in[4:2];
	assign wd  = pwdata_in[7:0];
	assign ext = extended_control_one_ff[`BSP_EXTENDED_CONTROL_ONE_EXT];
	assign mode = ext ? BSP_MODE_EXT :
	              (fcr_ff[`BSP_FCR_EN] ? BSP_MODE_FIFO : BSP_MODE_BASIC); // R1
	assign loop = ext ? extended_control_one_ff[`BSP_EXTENDED_CONTROL_ONE_LOOP] : mcr_ff[`BSP_MCR_LOOP];

	// FIFOs, baud timing and status wires
	logic [7:0]       tx_head, rx_head, rx_word;
	logic             tx_full_raw, tx_empty, rx_full_raw, rx_empty;
	logic             tx_push, tx_pop, rx_push, rx_pop, tx_full, rx_full;
	logic [LVL_W-1:0] tx_lvl, rx_lvl;
	logic [4:0]       rx_thr;

	assign tx_full = fcr_ff[`BSP_FCR_EN] ? tx_full_raw : !tx_empty;
	assign rx_full = fcr_ff[`BSP_FCR_EN] ? rx_full_raw : !rx_empty;
	assign tx_push = wr && bank_ff == 2'd0 && ofs == `BSP_OFS_DATA
	                 && !tx_full; // R9
	assign rx_pop  = rd && bank_ff == 2'd0 && ofs == `BSP_OFS_DATA; // R9

	bsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) u_tx_fifo (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.flush_in  (wr && bank_ff == 2'd0 && ofs == `BSP_OFS_EIR
		            && wd[`BSP_FCR_TXSR]),
		.push_in   (tx_push),
		.wdata_in  (wd),
		.pop_in    (tx_pop),
		.rdata_out (tx_head),
		.full_out  (tx_full_raw),
		.empty_out (tx_empty),
		.level_out (tx_lvl)
	);

	bsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) u_rx_fifo (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.flush_in  (wr && bank_ff == 2'd0 && ofs == `BSP_OFS_EIR
		            && wd[`BSP_FCR_RXSR]),
		.push_in   (rx_push),
		.wdata_in  (rx_word),
		.pop_in    (rx_pop),
		.rdata_out (rx_head),
		.full_out  (rx_full_raw),
		.empty_out (rx_empty),
		.level_out (rx_lvl)
	);

	bsp_baud_gen u_baud (
		.mclk_in    (mclk_in),
		.rst_in     (rst_in),
		.divisor_in (ext ? adiv_ff : ldiv_ff), // R12 R13
		.tick_out   (tick)
	);

	// Control registers
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			bank_ff  <= 2'd0; // R8
			bsel_ff  <= `BSP_RST_REG;
			lcr_ff   <= `BSP_RST_LCR;
			fcr_ff   <= `BSP_RST_FCR; // R5
			ier_ff   <= `BSP_RST_REG;
			mcr_ff   <= `BSP_RST_REG;
			spr_ff   <= `BSP_RST_REG;
			extended_control_one_ff <= `BSP_RST_REG;
			extended_control_two_ff <= `BSP_RST_REG;
			ldiv_ff  <= `BSP_RST_DIV;
			adiv_ff  <= `BSP_RST_DIV;
		end else if (wr && ofs == `BSP_OFS_BANKSEL) begin // R7
			bsel_ff <= wd;
			if (wd[`BSP_BSEL_FLAG] && wd[6:0] != `BSP_BSEL_BANK1) begin // R17
				if (wd[6:0] == `BSP_BSEL_BANK2) begin
					bank_ff <= 2'd2;
				end else if (wd[6:0] == `BSP_BSEL_BANK3) begin
					bank_ff <= 2'd3;
				end
			end else begin // R10
				lcr_ff  <= wd;
				bank_ff <= wd[`BSP_BSEL_FLAG] ? 2'd1 : 2'd0;
				if (wd[`BSP_BSEL_FLAG]) begin
					extended_control_one_ff[`BSP_EXTENDED_CONTROL_ONE_EXT] <= 1'b0; // R5
				end
			end
		end else if (wr) begin // R6 R18
			case ({bank_ff, ofs})
			{2'd0, `BSP_OFS_IER}: ier_ff <= wd;
			{2'd0, `BSP_OFS_EIR}: begin
				fcr_ff <= wd & ~8'h06;
			end
			{2'd0, `BSP_OFS_MCR}: mcr_ff <= wd;
			{2'd0, `BSP_OFS_SPR}: begin
				if (!ext) begin
					spr_ff <= wd; // R11
				end
			end
			{2'd1, `BSP_OFS_DIV_LOW}: begin
				ldiv_ff[7:0] <= wd; // R12
				extended_control_one_ff[`BSP_EXTENDED_CONTROL_ONE_EXT] <= 1'b0; // R5
			end
			{2'd1, `BSP_OFS_DIV_HIGH}: begin
				ldiv_ff[15:8] <= wd;
				extended_control_one_ff[`BSP_EXTENDED_CONTROL_ONE_EXT] <= 1'b0;
			end
			{2'd2, `BSP_OFS_DIV_LOW}: adiv_ff[7:0] <= wd; // R13
			{2'd2, `BSP_OFS_DIV_HIGH}: adiv_ff[15:8] <= wd;
			{2'd2, `BSP_OFS_EXTENDED_CONTROL_ONE}: extended_control_one_ff <= wd;
			{2'd2, `BSP_OFS_EXTENDED_CONTROL_TWO}: extended_control_two_ff <= wd;
			default: begin
			end
			endcase
		end
	end

	// Transmitter
	bsp_tx_e    tx_st_ff;
	logic [11:0] tx_frame_ff, tx_frame;
	logic [3:0]  tx_bits_ff, tx_tick_ff, wl, tx_nbits;
	logic [7:0]  wl_mask, tx_word;
	logic        tx_par, tx_line_ff, tx_idle_prev_ff, txlow_prev_ff;

	assign wl      = 4'd5 + {2'b00, lcr_ff[1:0]};
	assign wl_mask = 8'hff >> (4'd8 - wl);
	assign tx_pop  = (tx_st_ff == BSP_TX_IDLE) && !tx_empty;
	assign tx_nbits = 4'd2 + wl + {3'b000, lcr_ff[`BSP_LCR_PEN]}
	                  + {3'b000, lcr_ff[`BSP_LCR_STB]};

	always_comb begin // R3
		tx_word  = tx_head & wl_mask;
		tx_par   = lcr_ff[`BSP_LCR_STKP] ? !lcr_ff[`BSP_LCR_EPS]
		           : ((^tx_word) ^ !lcr_ff[`BSP_LCR_EPS]);
		tx_frame = 12'hfff;
		tx_frame[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(wl)) begin
				tx_frame[i + 1] = tx_word[i];
			end
		end
		if (lcr_ff[`BSP_LCR_PEN]) begin
			tx_frame[wl + 4'd1] = tx_par;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin // R2 R4
		if (rst_in) begin
			tx_st_ff    <= BSP_TX_IDLE;
			tx_frame_ff <= 12'hfff;
			tx_bits_ff  <= 4'h0;
			tx_tick_ff  <= 4'h0;
			tx_line_ff  <= 1'b1;
		end else begin
			tx_line_ff <= tx_frame_ff[0] && !lcr_ff[`BSP_LCR_SBRK];
			case (tx_st_ff)
			BSP_TX_IDLE: begin
				if (tx_pop) begin
					tx_frame_ff <= tx_frame;
					tx_bits_ff  <= tx_nbits;
					tx_tick_ff  <= 4'h0;
					tx_st_ff    <= BSP_TX_SHIFT;
				end
			end
			BSP_TX_SHIFT: begin
				if (tick) begin
					tx_tick_ff <= tx_tick_ff + 4'h1;
					if (tx_tick_ff == 4'(`BSP_OVERSAMPLE - 1)) begin
						tx_frame_ff <= {1'b1, tx_frame_ff[11:1]};
						tx_bits_ff  <= tx_bits_ff - 4'h1;
						if (tx_bits_ff == 4'h1) begin
							tx_st_ff <= BSP_TX_IDLE;
						end
					end
				end
			end
			default: tx_st_ff <= BSP_TX_IDLE;
			endcase
		end
	end

	// Receiver
	bsp_rx_e    rx_st_ff;
	logic [8:0] rx_sh_ff, rx_al;
	logic [3:0] rx_tick_ff, rx_bits_ff, rx_nbits;
	logic       rx_line, rx_perr, rx_ferr, rx_brk, rx_stop_now;

	assign rx_line  = loop ? tx_line_ff : pin_sync_ff[0];
	assign rx_nbits = wl + {3'b000, lcr_ff[`BSP_LCR_PEN]};
	assign rx_stop_now = (rx_st_ff == BSP_RX_STOP) && tick
	                     && rx_tick_ff == 4'(`BSP_OVERSAMPLE - 1);
	assign rx_push  = rx_stop_now && !rx_full;

	always_comb begin // R3
		rx_al   = rx_sh_ff >> (4'd9 - rx_nbits);
		rx_word = rx_al[7:0] & wl_mask;
		rx_perr = lcr_ff[`BSP_LCR_PEN] && (rx_al[wl] != (lcr_ff[`BSP_LCR_STKP]
		          ? !lcr_ff[`BSP_LCR_EPS]
		          : ((^rx_word) ^ !lcr_ff[`BSP_LCR_EPS])));
		rx_ferr = !rx_line;
		rx_brk  = !rx_line && rx_al == 9'h000;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin // R2 R4
		if (rst_in) begin
			rx_st_ff   <= BSP_RX_IDLE;
			rx_sh_ff   <= 9'h000;
			rx_tick_ff <= 4'h0;
			rx_bits_ff <= 4'h0;
		end else begin
			case (rx_st_ff)
			BSP_RX_IDLE: begin
				rx_tick_ff <= 4'h0;
				rx_bits_ff <= 4'h0;
				if (!rx_line) begin
					rx_st_ff <= BSP_RX_START;
				end
			end
			BSP_RX_START: begin
				if (tick) begin
					rx_tick_ff <= rx_tick_ff + 4'h1;
					// Mid-bit check rejects short glitches
					if (rx_tick_ff == 4'(`BSP_OVERSAMPLE / 2 - 1)) begin
						rx_tick_ff <= 4'h0;
						rx_st_ff   <= rx_line ? BSP_RX_IDLE : BSP_RX_DATA;
					end
				end
			end
			BSP_RX_DATA: begin
				if (tick) begin
					rx_tick_ff <= rx_tick_ff + 4'h1;
					if (rx_tick_ff == 4'(`BSP_OVERSAMPLE - 1)) begin
						rx_sh_ff   <= {rx_line, rx_sh_ff[8:1]};
						rx_bits_ff <= rx_bits_ff + 4'h1;
						if (rx_bits_ff == rx_nbits - 4'h1) begin
							rx_st_ff <= BSP_RX_STOP;
						end
					end
				end
			end
			BSP_RX_STOP: begin
				if (tick) begin
					rx_tick_ff <= rx_tick_ff + 4'h1;
				end
				if (rx_stop_now) begin
					rx_st_ff <= BSP_RX_IDLE;
				end
			end
			default: rx_st_ff <= BSP_RX_IDLE;
			endcase
		end
	end

	// Line and modem status, sticky until read; a set wins over the clear
	logic rd_lsr, rd_msr, rd_eir, ls_new;
	logic [3:0] dlt_set;
	assign rd_lsr = rd && bank_ff == 2'd0 && ofs == `BSP_OFS_LSR;
	assign rd_msr = rd && bank_ff == 2'd0 && ofs == `BSP_OFS_MSR;
	assign rd_eir = rd && bank_ff == 2'd0 && ofs == `BSP_OFS_EIR;
	assign ls_new = rx_stop_now && (rx_perr || rx_ferr || rx_full);
	// Modem inputs, active high: {dcd, ri, dsr, cts}
	assign mdm_now = loop ? {mcr_ff[`BSP_MCR_DCDLP], mcr_ff[`BSP_MCR_RILP],
	                         mcr_ff[`BSP_MCR_DTR], mcr_ff[`BSP_MCR_RTS]}
	                      : ~pin_sync_ff[4:1];
	assign dlt_set = {mdm_now[3] ^ mdm_prev_ff[3],
	                  mdm_prev_ff[2] && !mdm_now[2],
	                  mdm_now[1:0] ^ mdm_prev_ff[1:0]};

	always_ff @(posedge mclk_in or posedge rst_in) begin // R16
		if (rst_in) begin
			oe_ff       <= 1'b0;
			pe_ff       <= 1'b0;
			fe_ff       <= 1'b0;
			brk_ff      <= 1'b0;
			dlt_ff      <= 4'h0;
			mdm_prev_ff <= 4'h0;
		end else begin
			mdm_prev_ff <= mdm_now;
			oe_ff  <= (rx_stop_now && rx_full) || (oe_ff && !rd_lsr);
			pe_ff  <= (rx_stop_now && rx_perr) || (pe_ff && !rd_lsr);
			fe_ff  <= (rx_stop_now && rx_ferr) || (fe_ff && !rd_lsr);
			brk_ff <= (rx_stop_now && rx_brk) || (brk_ff && !rd_lsr);
			dlt_ff <= dlt_set | (rd_msr ? 4'h0 : dlt_ff);
		end
	end

	// Event bits, cleared by reading event identification
	logic [7:0] ev_set, ev_pend;
	logic       tx_idle_now, rx_hit;
	assign tx_idle_now = tx_empty && tx_st_ff == BSP_TX_IDLE;
	assign rx_thr = fcr_ff[7:6] == 2'd0 ? 5'd1 : fcr_ff[7:6] == 2'd1 ? 5'd4 :
	                fcr_ff[7:6] == 2'd2 ? 5'd8 : 5'd14;
	assign rx_hit = fcr_ff[`BSP_FCR_EN] ? (5'(rx_lvl) >= rx_thr) : !rx_empty;
	always_comb begin
		ev_set = 8'h00;
		ev_set[`BSP_EV_RX]    = rx_hit;
		ev_set[`BSP_EV_TXLOW] = tx_empty && !txlow_prev_ff;
		ev_set[`BSP_EV_LS]    = ls_new;
		ev_set[`BSP_EV_MS]    = |dlt_set;
		ev_set[`BSP_EV_TXEMP] = tx_idle_now && !tx_idle_prev_ff;
	end
	assign ev_pend = evt_ff & ier_ff
	                 & ((mode == BSP_MODE_EXT) ? `BSP_EV_MASK_EXT
	                                           : `BSP_EV_MASK_LEG);

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			evt_ff          <= 8'h00;
			txlow_prev_ff   <= 1'b1;
			tx_idle_prev_ff <= 1'b1;
			irq_out         <= 1'b0;
		end else begin
			txlow_prev_ff   <= tx_empty;
			tx_idle_prev_ff <= tx_idle_now;
			evt_ff  <= ev_set | (rd_eir ? 8'h00 : evt_ff);
			irq_out <= |ev_pend;
		end
	end

	// Read decode
	always_comb begin // R6 R18
		rd_val = 8'h00;
		case ({bank_ff, ofs})
		{2'd0, `BSP_OFS_DATA}: rd_val = rx_head; // R9
		{2'd0, `BSP_OFS_IER}:  rd_val = ier_ff;
		{2'd0, `BSP_OFS_EIR}: begin // R9
			if (ext) begin
				rd_val = evt_ff & `BSP_EV_MASK_EXT;
			end else begin
				rd_val = {{2{fcr_ff[`BSP_FCR_EN]}}, 4'h0, 2'b01};
				if (ev_pend[`BSP_EV_LS]) begin
					rd_val[3:0] = 4'h6;
				end else if (ev_pend[`BSP_EV_RX]) begin
					rd_val[3:0] = 4'h4;
				end else if (ev_pend[`BSP_EV_TXLOW]) begin
					rd_val[3:0] = 4'h2;
				end else if (ev_pend[`BSP_EV_MS]) begin
					rd_val[3:0] = 4'h0;
				end
			end
		end
		{2'd0, `BSP_OFS_MCR}: rd_val = mcr_ff;
		{2'd0, `BSP_OFS_LSR}: begin // R16
			rd_val = {pe_ff || fe_ff || brk_ff, tx_idle_now, tx_empty,
			          brk_ff, fe_ff, pe_ff, oe_ff, !rx_empty};
		end
		{2'd0, `BSP_OFS_MSR}: rd_val = {mdm_now, dlt_ff}; // R16
		{2'd0, `BSP_OFS_SPR}: rd_val = ext ? 8'h00 : spr_ff; // R11
		{2'd1, `BSP_OFS_DIV_LOW}:  rd_val = ldiv_ff[7:0]; // R12
		{2'd1, `BSP_OFS_DIV_HIGH}: rd_val = ldiv_ff[15:8];
		{2'd2, `BSP_OFS_DIV_LOW}:  rd_val = adiv_ff[7:0]; // R13
		{2'd2, `BSP_OFS_DIV_HIGH}: rd_val = adiv_ff[15:8];
		{2'd2, `BSP_OFS_EXTENDED_CONTROL_ONE}:    rd_val = extended_control_one_ff;
		{2'd2, `BSP_OFS_EXTENDED_CONTROL_TWO}:    rd_val = extended_control_two_ff;
		{2'd2, `BSP_OFS_TX_FIFO_LEVEL}:    rd_val = {3'b000, 5'(tx_lvl)};
		{2'd2, `BSP_OFS_RX_FIFO_LEVEL}:    rd_val = {3'b000, 5'(rx_lvl)};
		{2'd3, `BSP_OFS_MODULE_REVISION}:     rd_val = {MODULE_CODE, REVISION_CODE}; // R14
		{2'd3, `BSP_OFS_LINE_FORMAT_SHADOW}:   rd_val = lcr_ff; // R15
		{2'd3, `BSP_OFS_FIFO_CONTROL_SHADOW}:   rd_val = fcr_ff; // R15
		default: rd_val = 8'h00;
		endcase
		if (ofs == `BSP_OFS_BANKSEL) begin
			rd_val = bsel_ff; // R7
		end
	end

	// Bus answer and pins
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
			txd_out     <= 1'b1;
			rts_n_out   <= 1'b1;
			dtr_n_out   <= 1'b1;
		end else begin
			pready_out  <= acc_fire;
			pslverr_out <= 1'b0;
			if (rd) begin
				prdata_out <= {24'h00_0000, rd_val};
			end
			txd_out   <= loop ? 1'b1 : tx_line_ff;
			rts_n_out <= loop ? 1'b1 : !mcr_ff[`BSP_MCR_RTS];
			dtr_n_out <= loop ? 1'b1 : !mcr_ff[`BSP_MCR_DTR];
		end
	end
endmodule : bsp_serial_port
`default_nettype wire

// ==== tb/bsp_remote_peer.sv ====
// Remote peer model: echoes serial data and handshakes back
`timescale 1ns/1ns
`default_nettype none
module bsp_remote_peer (
	input  wire logic txd_in,
	input  wire logic rts_n_in,
	input  wire logic dtr_n_in,
	input  wire logic carrier_n_in,
	output logic      rxd_out,
	output logic      cts_n_out,
	output logic      dsr_n_out,
	output logic      ri_n_out,
	output logic      dcd_n_out
);
	// Echo each character straight back
	assign rxd_out   = txd_in;
	assign cts_n_out = rts_n_in;
	assign dsr_n_out = dtr_n_in;
	assign ri_n_out  = 1'b1;
	assign dcd_n_out = carrier_n_in;
endmodule : bsp_remote_peer
`default_nettype wire

// ==== tb/bsp_serial_port_sva.sv ====
// Bus and pin checks for the banked serial port
`timescale 1ns/1ns
`default_nettype none
module bsp_serial_port_sva (
	input wire logic        mclk_in,
	input wire logic        rst_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out,
	input wire logic        txd_out,
	input wire logic        rts_n_out,
	input wire logic        dtr_n_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	sequence s_acc; psel_in && penable_in && !pready_out; endsequence
	property p_answer; s_acc |=> pready_out; endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_pulse; pready_out |=> !pready_out; endproperty
	a_pulse: assert property (p_pulse) else $error("long ready");
	property p_cause; $rose(pready_out) |-> $past(psel_in && penable_in);
	endproperty
	a_cause: assert property (p_cause) else $error("stray ready");
	property p_noerr; !pslverr_out; endproperty
	a_noerr: assert property (p_noerr) else $error("slave error");
	property p_upper; pready_out |-> prdata_out[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper bits");
	property p_hold;
		$changed(prdata_out) |-> $past(psel_in && penable_in && !pwrite_in);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_start; $fell(txd_out) |=> !txd_out [*8]; endproperty
	a_start: assert property (p_start) else $error("short start");
	property p_rts;
		$changed(rts_n_out) |-> $past(psel_in && pwrite_in);
	endproperty
	a_rts: assert property (p_rts) else $error("rts moved");
	property p_dtr;
		$changed(dtr_n_out) |-> $past(psel_in && pwrite_in);
	endproperty
	a_dtr: assert property (p_dtr) else $error("dtr moved");
endmodule : bsp_serial_port_sva
bind bsp_serial_port bsp_serial_port_sva i_sva (
	.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in),
	.prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .txd_out(txd_out),
	.rts_n_out(rts_n_out), .dtr_n_out(dtr_n_out)
);
`default_nettype wire

// ==== tb/tb.sv ====
// Register and line bench for the banked serial port
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [4:0]  paddr = 5'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic        pready, pslverr, rxd, cts_n, dsr_n, ri_n, dcd_n;
	logic        txd, rts_n, dtr_n, irq;
	logic        carrier_n = 1'b1;
	int          miscompares = 0;
	int          total_checks = 0;
	always #4 mclk_in = ~mclk_in;
	bsp_serial_port i_dut (
		.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .rxd_in(rxd), .cts_n_in(cts_n),
		.dsr_n_in(dsr_n), .ri_n_in(ri_n), .dcd_n_in(dcd_n),
		.txd_out(txd), .rts_n_out(rts_n), .dtr_n_out(dtr_n),
		.irq_out(irq)
	);
	bsp_remote_peer i_peer (
		.txd_in(txd), .rts_n_in(rts_n), .dtr_n_in(dtr_n),
		.carrier_n_in(carrier_n), .rxd_out(rxd), .cts_n_out(cts_n),
		.dsr_n_out(dsr_n), .ri_n_out(ri_n), .dcd_n_out(dcd_n)
	);
	task summarize;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk
	task xfer(input logic w, input logic [2:0] i, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge mclk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			summarize();
		end
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk_in);
	endtask : xfer
	task wr(input logic [2:0] i, input logic [7:0] d);
		xfer(1'b1, i, d);
	endtask : wr
	task rd(input logic [2:0] i, input logic [7:0] e);
		xfer(1'b0, i, 8'h00);
		chk($sformatf("offset %0d", i), {24'h0, e}, rdat);
	endtask : rd
	task wirq(input logic e);
		int n;
		n = 0;
		while (irq !== e && n < 2000) begin
			@(posedge mclk_in);
			n++;
		end
		chk("irq", {31'h0, e}, {31'h0, irq});
		if (n >= 2000)
			summarize();
	endtask : wirq
	initial begin
		repeat (20) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		wr(3'h7, 8'ha5);
		rd(3'h7, 8'ha5);
		rd(3'h1, 8'h00);
		wr(3'h2, 8'hc7);
		wr(3'h3, 8'he4);
		rd(3'h0, 8'h51);
		rd(3'h1, 8'h03);
		rd(3'h2, 8'hc1);
		rd(3'h3, 8'he4);
		for (int i = 4; i < 8; i++) begin
			wr(i[2:0], 8'hff);
			rd(i[2:0], 8'h00);
		end
		wr(3'h3, 8'he0);
		wr(3'h0, 8'h34);
		rd(3'h0, 8'h34);
		rd(3'h6, 8'h00);
		rd(3'h5, 8'h00);
		rd(3'h3, 8'he0);
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h00);
		rd(3'h0, 8'h01);
		rd(3'h1, 8'h00);
		wr(3'h2, 8'hff);
		rd(3'h2, 8'h00);
		wr(3'h3, 8'h03);
		wr(3'h2, 8'h01);
		wr(3'h1, 8'h01);
		wr(3'h0, 8'h5a);
		wirq(1'b1);
		rd(3'h0, 8'h5a);
		// Receive event stays pending until identification is read
		rd(3'h2, 8'hc4);
		wirq(1'b0);
		repeat (20) @(posedge mclk_in);
		rd(3'h5, 8'h60);
		// Masked event must not reach the pin
		wr(3'h1, 8'h00);
		wr(3'h0, 8'h3c);
		repeat (300) @(posedge mclk_in);
		chk("irq", 32'h0, {31'h0, irq});
		wr(3'h1, 8'h01);
		wirq(1'b1);
		rd(3'h0, 8'h3c);
		wr(3'h4, 8'h03);
		repeat (4) @(posedge mclk_in);
		chk("rts_dtr", 32'h0, {30'h0, rts_n, dtr_n});
		rd(3'h6, 8'h33);
		rd(3'h6, 8'h30);
		carrier_n <= 1'b0;
		repeat (4) @(posedge mclk_in);
		rd(3'h6, 8'hb8);
		wr(3'h3, 8'he0);
		wr(3'h2, 8'h01);
		wr(3'h3, 8'h03);
		wr(3'h7, 8'h77);
		rd(3'h7, 8'h00);
		wr(3'h3, 8'h80);
		wr(3'h3, 8'h03);
		wr(3'h7, 8'h77);
		rd(3'h7, 8'h77);
		summarize();
	end
endmodule : tb
`default_nettype wire
